// ===== core/fps_pkg.sv
/*
  fps_pkg: constants shared by the flash program/erase host controller.
  assumes a 200 MHz core clock and a boot-block flash on an async parallel bus.
*/
`default_nettype none
package fps_pkg;
  // clock and strobe timing
  localparam int CLK_PERIOD_PS = 5000;
  localparam int WE_LOW_NS = 50; // least write strobe width
  localparam int RD_ACCESS_NS = 120; // least output valid time after strobes
  localparam int GAP_NS = 30; // least strobe high time between cycles
  localparam int WE_CYC = (WE_LOW_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
  localparam int RD_CYC = (RD_ACCESS_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
  localparam int GAP_CYC = (GAP_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
  localparam int CNT_W = 6;
  // flash command codes
  localparam logic [7:0] CMD_READ_ARRAY = 8'hff;
  localparam logic [7:0] CMD_READ_STATUS = 8'h70;
  localparam logic [7:0] CMD_CLEAR_STATUS = 8'h50;
  localparam logic [7:0] CMD_PROGRAM = 8'h40;
  localparam logic [7:0] CMD_ERASE = 8'h20;
  localparam logic [7:0] CMD_CONFIRM = 8'hd0;
  localparam logic [7:0] CMD_SUSPEND = 8'hb0;
  // flash operation_status layout
  localparam int SR_READY = 7;
  localparam int SR_SUSP = 6;
  localparam int SR_ERASE_ERR = 5;
  localparam int SR_PROG_ERR = 4;
  localparam int SR_SUPPLY_ERR = 3;
  localparam logic [7:0] SR_USED_MASK = 8'hf8;
  // controller register offsets (byte addresses)
  localparam logic [4:0] REG_CTRL = 5'h00;
  localparam logic [4:0] REG_ADDR = 5'h04;
  localparam logic [4:0] REG_WDATA = 5'h08;
  localparam logic [4:0] REG_STAT = 5'h0c;
  localparam logic [4:0] REG_PINS = 5'h10;
  localparam logic [4:0] REG_RDATA = 5'h14;
  // ctrl / stat / pins fields
  localparam int CTRL_START = 3;
  localparam int STAT_BUSY = 0;
  localparam int STAT_DONE = 1;
  localparam int STAT_SR_LSB = 8;
  localparam int PIN_RESET = 0;
  localparam int PIN_WP = 1;
  localparam int PIN_ELEV = 2;
  localparam logic [2:0] PINS_RESET_VAL = 3'h0;
  localparam logic [1:0] AXI_OKAY = 2'h0;
  localparam logic [1:0] AXI_SLVERR = 2'h2;
  typedef enum logic [2:0] {
    OP_PROGRAM, OP_ERASE, OP_SUSPEND, OP_RESUME, OP_CLEAR, OP_READ, OP_STATUS
  } fps_op_t;
endpackage
`default_nettype wire

// ===== core/fps_host.sv
/*
  fps_host: host controller driving a boot-block flash over its async pins.
  assumes software programs it over axi4-lite; dq is split into in/out/enable.
*/
// The placing of the registers and the AXI4-Lite interface to the registers were chosen for this implementation.
`default_nettype none
module fps_host
  import fps_pkg::*;
#(
  parameter int AW = 18
) (
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic [5:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [5:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  output logic [AW-1:0] flash_addr,
  output logic [15:0] flash_dq_o,
  output logic flash_dq_oe,
  input wire logic [15:0] flash_dq_i,
  output logic flash_ce_n,
  output logic flash_oe_n,
  output logic flash_we_n,
  output logic reset_powerdown_n,
  output logic flash_wp_n,
  output logic elevated_unlock_level
);
  typedef enum {S_IDLE, S_WR, S_RD, S_RDWAIT, S_GAP} fps_state_t;
  typedef enum {K_WRITE, K_READ, K_POLL, K_END} fps_kind_t;

  fps_state_t state_q;
  fps_op_t op_q;
  logic [2:0] step_q;
  logic [CNT_W-1:0] cnt_q;
  logic [AW-1:0] addr_q;
  logic [15:0] wdata_q, rdata_q;
  logic [7:0] sr_q;
  logic done_q;
  logic [2:0] pins_q;
  logic [15:0] dq_s1_q, dq_s2_q, dq_s3_q;
  logic aw_full_q, w_full_q;
  logic [5:0] awaddr_q;
  logic [31:0] wbus_q;
  fps_kind_t kind;
  logic [7:0] cmd;
  logic use_addr, wr_fire, start, poll_ready, susp_take, susp_q;

  // step table: what each step of each operation puts on the pins
  // command codes per step
  always_comb begin
    kind = K_END;
    cmd = CMD_READ_STATUS;
    use_addr = 1'b0;
    unique case (op_q)
      OP_PROGRAM: begin
        kind = (step_q == 3'd3) ? K_POLL : (step_q < 3'd3) ? K_WRITE : K_END;
        cmd = (step_q == 3'd0) ? CMD_PROGRAM : CMD_READ_STATUS;
        use_addr = (step_q < 3'd2);
      end
      // erase setup then confirm at block
      OP_ERASE: begin
        kind = (step_q == 3'd3) ? K_POLL : (step_q < 3'd3) ? K_WRITE : K_END;
        cmd = (step_q == 3'd0) ? CMD_ERASE : (step_q == 3'd1) ? CMD_CONFIRM : CMD_READ_STATUS;
        use_addr = (step_q < 3'd2);
      end
      OP_SUSPEND: begin
        kind = (step_q == 3'd2) ? K_POLL : (step_q < 3'd2) ? K_WRITE : K_END;
        cmd = (step_q == 3'd0) ? CMD_SUSPEND : CMD_READ_STATUS;
      end
      // chip select asserted with resume write
      OP_RESUME: begin
        kind = (step_q == 3'd2) ? K_POLL : (step_q < 3'd2) ? K_WRITE : K_END;
        cmd = (step_q == 3'd0) ? CMD_CONFIRM : CMD_READ_STATUS;
      end
      OP_CLEAR: begin
        kind = (step_q == 3'd0) ? K_WRITE : K_END;
        cmd = CMD_CLEAR_STATUS;
      end
      OP_READ: begin
        kind = (step_q == 3'd0) ? K_WRITE : (step_q == 3'd1) ? K_READ : K_END;
        cmd = CMD_READ_ARRAY;
        use_addr = (step_q == 3'd1);
      end
      OP_STATUS: begin
        kind = (step_q == 3'd0) ? K_WRITE : (step_q == 3'd1) ? K_POLL : K_END;
      end
      default: kind = K_END;
    endcase
  end

  // ready bit taken from low data lines
  assign poll_ready = dq_s3_q[SR_READY];

  // three-stage pin synchroniser on the data lines
  always_ff @(posedge clk) begin
    dq_s1_q <= flash_dq_i;
    dq_s2_q <= dq_s1_q;
    dq_s3_q <= dq_s2_q;
  end

  // axi write channel capture and response
  assign wr_fire = aw_full_q && w_full_q && !s_axi_bvalid;
  assign start = wr_fire && (awaddr_q[4:0] == REG_CTRL) && wbus_q[CTRL_START] && state_q == S_IDLE;
  // suspend accepted only while an erase runs
  assign susp_take = wr_fire && (awaddr_q[4:0] == REG_CTRL) && wbus_q[CTRL_START] && op_q == OP_ERASE
    && state_q != S_IDLE && fps_op_t'(wbus_q[2:0]) == OP_SUSPEND;
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      aw_full_q <= 1'b0;
      w_full_q <= 1'b0;
      awaddr_q <= '0;
      wbus_q <= '0;
      s_axi_awready <= 1'b0;
      s_axi_wready <= 1'b0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= AXI_OKAY;
    end else begin
      s_axi_awready <= !aw_full_q && s_axi_awvalid && !s_axi_awready;
      s_axi_wready <= !w_full_q && s_axi_wvalid && !s_axi_wready;
      if (s_axi_awvalid && s_axi_awready) begin
        aw_full_q <= 1'b1;
        awaddr_q <= s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_full_q <= 1'b1;
        wbus_q <= s_axi_wdata;
      end
      if (wr_fire) begin
        aw_full_q <= 1'b0;
        w_full_q <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= (awaddr_q[4:0] > REG_RDATA || awaddr_q[1:0] != 2'h0) ? AXI_SLVERR : AXI_OKAY;
      end else if (s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end

  // software registers: address, data, pin levels
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      addr_q <= '0;
      wdata_q <= '0;
      pins_q <= PINS_RESET_VAL;
    end else if (wr_fire && s_axi_wstrb != 4'h0) begin
      if (awaddr_q[4:0] == REG_ADDR) addr_q <= wbus_q[AW-1:0];
      if (awaddr_q[4:0] == REG_WDATA) wdata_q <= wbus_q[15:0];
      if (awaddr_q[4:0] == REG_PINS) pins_q <= wbus_q[2:0];
    end
  end

  // write-protect, elevated unlock, reset clears flash status
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      reset_powerdown_n <= 1'b0;
      flash_wp_n <= 1'b0;
      elevated_unlock_level <= 1'b0;
    end else begin
      reset_powerdown_n <= pins_q[PIN_RESET];
      flash_wp_n <= pins_q[PIN_WP];
      elevated_unlock_level <= pins_q[PIN_ELEV] && pins_q[PIN_RESET];
    end
  end

  // suspend request held until the erase poll in flight ends
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      susp_q <= 1'b0;
    end else if (susp_take) begin
      susp_q <= 1'b1;
    end else if (state_q == S_IDLE || (state_q == S_RDWAIT && dq_s2_q == dq_s3_q)) begin
      susp_q <= 1'b0;
    end
  end

  // bus cycle sequencer
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      state_q <= S_IDLE;
      op_q <= OP_STATUS;
      step_q <= '0;
      cnt_q <= '0;
      flash_ce_n <= 1'b1;
      flash_oe_n <= 1'b1;
      flash_we_n <= 1'b1;
      flash_dq_oe <= 1'b0;
      flash_dq_o <= '0;
      flash_addr <= '0;
      rdata_q <= '0;
      sr_q <= '0;
      done_q <= 1'b0;
    end else begin
      unique case (state_q)
        S_IDLE: begin
          if (start) begin
            op_q <= fps_op_t'(wbus_q[2:0]);
            step_q <= '0;
            state_q <= S_GAP;
            cnt_q <= '0;
          end
        end
        S_WR: begin
          cnt_q <= cnt_q + 1'b1;
          if (cnt_q == CNT_W'(WE_CYC - 1)) begin
            flash_ce_n <= 1'b1;
            flash_we_n <= 1'b1;
            step_q <= step_q + 1'b1;
            cnt_q <= '0;
            state_q <= S_GAP;
          end
        end
        S_RD: begin
          cnt_q <= cnt_q + 1'b1;
          if (cnt_q == CNT_W'(RD_CYC - 1)) state_q <= S_RDWAIT;
        end
        // sample once the two late stages agree
        S_RDWAIT: begin
          if (dq_s2_q == dq_s3_q) begin
            flash_ce_n <= 1'b1;
            flash_oe_n <= 1'b1;
            cnt_q <= '0;
            state_q <= S_GAP;
            if (kind == K_READ) begin
              rdata_q <= dq_s3_q;
              step_q <= step_q + 1'b1;
            end else begin
              sr_q <= dq_s3_q[7:0] & SR_USED_MASK;
              // keep polling status until ready; a pending suspend takes over
              if (susp_q) begin
                op_q <= OP_SUSPEND;
                step_q <= '0;
              end else if (poll_ready) begin
                step_q <= step_q + 1'b1;
              end
            end
          end
        end
        S_GAP: begin
          flash_dq_oe <= 1'b0;
          cnt_q <= cnt_q + 1'b1;
          if (cnt_q >= CNT_W'(GAP_CYC - 1)) begin
            cnt_q <= '0;
            flash_addr <= use_addr ? addr_q : '0;
            unique case (kind)
              K_WRITE: begin
                flash_dq_o <= (op_q == OP_PROGRAM && step_q == 3'd1) ? wdata_q : {8'h00, cmd};
                flash_dq_oe <= 1'b1;
                flash_ce_n <= 1'b0;
                flash_we_n <= 1'b0;
                state_q <= S_WR;
              end
              K_READ, K_POLL: begin
                flash_ce_n <= 1'b0;
                flash_oe_n <= 1'b0;
                state_q <= S_RD;
              end
              K_END: begin
                done_q <= 1'b1;
                state_q <= S_IDLE;
              end
            endcase
          end
        end
      endcase
      // done is cleared by a start; a finishing op in that cycle cannot coincide
      if (start) done_q <= 1'b0;
    end
  end

  // axi read channel
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= '0;
      s_axi_rresp <= AXI_OKAY;
    end else begin
      s_axi_arready <= s_axi_arvalid && !s_axi_arready && !s_axi_rvalid;
      if (s_axi_arvalid && s_axi_arready) begin
        s_axi_rvalid <= 1'b1;
        s_axi_rresp <= AXI_OKAY;
        unique case (s_axi_araddr[4:0])
          REG_CTRL: s_axi_rdata <= {29'h0, op_q};
          REG_ADDR: s_axi_rdata <= 32'(addr_q);
          REG_WDATA: s_axi_rdata <= {16'h0, wdata_q};
          REG_STAT: s_axi_rdata <= {16'h0, sr_q, 6'h0, done_q, state_q != S_IDLE};
          REG_PINS: s_axi_rdata <= {29'h0, pins_q};
          REG_RDATA: s_axi_rdata <= {16'h0, rdata_q};
          default: begin
            s_axi_rdata <= '0;
            s_axi_rresp <= AXI_SLVERR;
          end
        endcase
      end else if (s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
      end
    end
  end
endmodule
`default_nettype wire

// ===== bench/fps_host_monitor.sv
/*
  fps_host_monitor: timing and level checks on the flash pins and axi reads.
  assumes it is bound into fps_host and sees only its ports.
*/
`default_nettype none
module fps_host_monitor
  import fps_pkg::*;
(
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic [31:0] s_axi_rdata,
  input wire logic [1:0] s_axi_rresp,
  input wire logic s_axi_rvalid,
  input wire logic [17:0] flash_addr,
  input wire logic [15:0] flash_dq_o,
  input wire logic flash_dq_oe,
  input wire logic flash_ce_n,
  input wire logic flash_oe_n,
  input wire logic flash_we_n,
  input wire logic reset_powerdown_n,
  input wire logic flash_wp_n,
  input wire logic elevated_unlock_level
);
  logic [CNT_W-1:0] we_q;
  logic [CNT_W-1:0] oe_q;
  default clocking @(posedge clk); endclocking
  default disable iff (sys_rst);
  // low-time counters of the two strobes
  always_ff @(posedge clk) we_q <= (sys_rst || flash_we_n) ? '0 : we_q + 1'b1;
  always_ff @(posedge clk) oe_q <= (sys_rst || flash_oe_n) ? '0 : oe_q + 1'b1;
  a_write_width: assert property ($rose(flash_we_n) |-> we_q == WE_CYC)
    else $error("write strobe width wrong");
  a_read_width: assert property ($rose(flash_oe_n) |-> oe_q >= RD_CYC)
    else $error("read strobe too short");
  a_write_drive: assert property (!flash_we_n |-> flash_dq_oe && !flash_ce_n && flash_oe_n)
    else $error("write cycle without data drive");
  a_read_release: assert property (!flash_oe_n |-> !flash_dq_oe && !flash_ce_n)
    else $error("read cycle with data drive");
  a_poll_toggle: assert property ($rose(flash_oe_n) |-> flash_oe_n [*4])
    else $error("read strobe not toggled between polls");
  a_upper_zero: assert property (!flash_we_n && flash_addr == '0 |-> flash_dq_o[15:8] == 8'h00)
    else $error("command upper byte not zero");
  a_elev_reset: assert property (elevated_unlock_level |-> reset_powerdown_n)
    else $error("elevated level with reset low");
  a_slverr_zero: assert property (s_axi_rvalid && s_axi_rresp == AXI_SLVERR |-> s_axi_rdata == 32'h0)
    else $error("refused read data not zero");
  c_write: cover property ($rose(flash_we_n));
  c_refused: cover property (s_axi_rvalid && s_axi_rresp == AXI_SLVERR);
  c_elev: cover property (elevated_unlock_level && !flash_wp_n);
endmodule
bind fps_host fps_host_monitor fps_host_monitor_i (.*);
`default_nettype wire

// ===== bench/fps_flash_model.sv
/*
  fps_flash_model: behavioural boot-block flash seen on the async pins.
  assumes the bench steers supply_ok and fail_op.
*/
`default_nettype none
module fps_flash_model #(
  parameter int BUSY_CYC = 40 // engine time, plain default
) (
  input wire logic clk,
  input wire logic [17:0] addr,
  input wire logic [15:0] dq_o,
  input wire logic dq_oe,
  output logic [15:0] dq_i,
  input wire logic ce_n,
  input wire logic oe_n,
  input wire logic we_n,
  input wire logic rp_n,
  input wire logic wp_n,
  input wire logic elev,
  input wire logic supply_ok,
  input wire logic fail_op
);
  logic [15:0] mem [0:255];
  logic [15:0] rd;
  logic [15:0] last = 16'h0;
  logic [7:0] sr = 8'h80;
  logic [7:0] sr_lat = 8'h80;
  logic st_mode = 1'b0;
  logic [1:0] pend = 2'd0;
  logic lock;
  logic wr_d = 1'b0;
  int busy = 0;
  initial foreach (mem[i]) mem[i] = 16'hffff;
  // boot block locked unless wp high or elevated
  assign lock = addr[17:13] == 5'h00 && !wp_n && !elev;
  always @(posedge clk or negedge rp_n) begin
    if (!rp_n) begin
      sr = 8'h80;
      st_mode = 1'b0;
      pend = 2'd0;
      busy = 0;
    end else if (wr_d && (ce_n || we_n)) begin
      if (pend == 2'd1) begin
        sr = sr | {3'b0, (lock || fail_op) && supply_ok, !supply_ok, 3'b0};
        if (supply_ok && !lock && !fail_op) mem[addr[7:0]] = mem[addr[7:0]] & dq_o;
      end else if (pend == 2'd2 && dq_o[7:0] == 8'hd0) begin
        sr = sr | {2'b0, !supply_ok || lock || fail_op, 1'b0, !supply_ok, 3'b0};
        if (supply_ok && !lock && !fail_op) foreach (mem[i]) mem[i] = 16'hffff;
      end
      if (pend != 2'd0) begin
        sr[7] = 1'b0;
        busy = BUSY_CYC;
        st_mode = 1'b1;
        pend = 2'd0;
      end else begin
        case (dq_o[7:0])
          8'h70: st_mode = 1'b1;
          8'hff: st_mode = 1'b0;
          8'h50: sr[5:3] = 3'h0;
          8'h40, 8'h10: pend = 2'd1;
          8'h20: pend = 2'd2;
          8'hb0: if (!sr[7]) sr[7:6] = 2'b11;
          8'hd0: if (sr[6]) sr[7:6] = 2'b00;
          default: ;
        endcase
      end
    end
    if (rp_n && busy > 0 && !sr[6]) begin
      busy--;
      if (busy == 0) sr[7] = 1'b1;
    end
    wr_d = rp_n && !ce_n && !we_n;
  end
  // status caught on the later falling strobe
  always @(negedge oe_n or negedge ce_n) if (!oe_n && !ce_n) sr_lat = sr;
  // status on the low byte, reserved bits read 101
  assign rd = st_mode ? {8'h00, sr_lat[7:3], 3'b101} : mem[addr[7:0]];
  always @* if (!ce_n && !oe_n && rp_n) last = rd;
  assign dq_i = (!ce_n && !oe_n && rp_n && !dq_oe) ? rd : ~last;
endmodule
`default_nettype wire

// ===== bench/fps_host_tb.sv
/*
  fps_host_tb: drives the controller over axi4-lite against the flash model.
  assumes the monitor is bound and the model stands on the flash pins.
*/
`default_nettype none
module fps_host_tb
  import fps_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  typedef struct {logic [31:0] d; logic [31:0] m; logic [1:0] r;} fps_exp_t;
  logic clk = 1'b0;
  logic sys_rst = 1'b1;
  logic [5:0] s_axi_awaddr = '0, s_axi_araddr = '0;
  logic [31:0] s_axi_wdata = '0, s_axi_rdata;
  logic [3:0] s_axi_wstrb = 4'hf;
  logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0, s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic [1:0] s_axi_bresp, s_axi_rresp;
  logic [17:0] flash_addr;
  logic [15:0] flash_dq_o, flash_dq_i;
  logic flash_dq_oe, flash_ce_n, flash_oe_n, flash_we_n, reset_powerdown_n, flash_wp_n, elevated_unlock_level;
  logic supply_ok = 1'b1, fail_op = 1'b0;
  int num_errors = 0, checked = 0;
  fps_exp_t exp_r[$];
  logic [1:0] exp_b[$];
  logic [19:0] tbl [8] = '{20'h03390, 20'h133a0, 20'h103a8, 20'h161a0, 20'h06190, 20'h12180, 20'h16580, 20'h06380};
  fps_host fps_host_i (.*);
  fps_flash_model #(.BUSY_CYC(400)) fps_flash_model_i (.clk(clk), .addr(flash_addr), .dq_o(flash_dq_o),
    .dq_oe(flash_dq_oe),
    .dq_i(flash_dq_i), .ce_n(flash_ce_n), .oe_n(flash_oe_n), .we_n(flash_we_n), .rp_n(reset_powerdown_n),
    .wp_n(flash_wp_n), .elev(elevated_unlock_level), .supply_ok(supply_ok), .fail_op(fail_op));
  always #2.5 clk = ~clk;
  function automatic logic [31:0] lfsr(input logic [31:0] x);
    return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
  endfunction
  task automatic give_verdict();
    if (num_errors == 0 && checked > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  task automatic axi_wr(input logic [4:0] a, input logic [31:0] d, input logic [1:0] r);
    @(posedge clk);
    exp_b.push_back(r);
    s_axi_awaddr <= {1'b0, a};
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    do begin
      @(posedge clk);
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
    end while (s_axi_bvalid !== 1'b1);
    s_axi_bready <= 1'b0;
  endtask
  task automatic axi_rd(input logic [4:0] a, input fps_exp_t e, output logic [31:0] q);
    @(posedge clk);
    exp_r.push_back(e);
    s_axi_araddr <= {1'b0, a};
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do begin
      @(posedge clk);
      if (s_axi_arready) s_axi_arvalid <= 1'b0;
    end while (s_axi_rvalid !== 1'b1);
    q = s_axi_rdata;
    s_axi_rready <= 1'b0;
  endtask
  task automatic chk(input logic [4:0] a, input logic [31:0] d, input logic [31:0] m, input logic [1:0] r);
    logic [31:0] q;
    axi_rd(a, '{d, m, r}, q);
  endtask
  task automatic chk_sr(input logic [7:0] s);
    chk(REG_STAT, {16'h0, s, 8'h02}, 32'hff03, AXI_OKAY);
  endtask
  // start one controller operation and poll until it is done
  task automatic op(input logic [2:0] c, input logic [17:0] a, input logic [15:0] d);
    logic [31:0] q;
    axi_wr(REG_ADDR, {14'h0, a}, AXI_OKAY);
    axi_wr(REG_WDATA, {16'h0, d}, AXI_OKAY);
    axi_wr(REG_CTRL, {28'h0, 1'b1, c}, AXI_OKAY);
    do axi_rd(REG_STAT, '{32'h0, 32'h0, AXI_OKAY}, q);
    while (q[STAT_BUSY] !== 1'b0 || q[STAT_DONE] !== 1'b1);
  endtask
  // watcher takes the oldest note for every answer
  always @(posedge clk) begin
    if (s_axi_rvalid === 1'b1 && s_axi_rready && exp_r.size() > 0) begin
      automatic fps_exp_t e = exp_r.pop_front();
      checked++;
      if ((s_axi_rdata & e.m) !== (e.d & e.m) || s_axi_rresp !== e.r) begin
        num_errors++;
        $display("CHECK FAILED rdata exp %h/%h seen %h/%h", e.d, e.r, s_axi_rdata, s_axi_rresp);
      end
    end
    if (s_axi_bvalid === 1'b1 && s_axi_bready && exp_b.size() > 0) begin
      automatic logic [1:0] r = exp_b.pop_front();
      checked++;
      if (s_axi_bresp !== r) begin
        num_errors++;
        $display("CHECK FAILED bresp exp %h seen %h", r, s_axi_bresp);
      end
    end
  end
  // watchdog against a hung poll
  initial begin
    repeat (80000) @(posedge clk);
    num_errors++;
    give_verdict();
  end
  // main sequence
  initial begin
    logic [31:0] r;
    logic [15:0] e;
    logic [17:0] a;
    r = lfsr(32'h63de);
    e = 16'hffff;
    a = {10'h080, r[7:0] | 8'h01};
    repeat (16) @(posedge clk);
    sys_rst <= 1'b0;
    chk(REG_PINS, 32'h0, 32'h7, AXI_OKAY);
    axi_wr(REG_PINS, 32'h3, AXI_OKAY);
    for (int i = 0; i < 2; i++) begin
      r = lfsr(r);
      e = e & r[15:0];
      op(OP_PROGRAM, a, r[15:0]);
      chk_sr(8'h80);
      op(OP_READ, a, 16'h0);
      chk(REG_RDATA, {16'h0, e}, 32'hffff, AXI_OKAY);
    end
    supply_ok <= 1'b0;
    op(OP_PROGRAM, a, 16'h0);
    chk_sr(8'h88);
    supply_ok <= 1'b1;
    op(OP_READ, a, 16'h0);
    chk(REG_RDATA, {16'h0, e}, 32'hffff, AXI_OKAY);
    op(OP_STATUS, a, 16'h0);
    chk_sr(8'h88);
    op(OP_CLEAR, a, 16'h0);
    op(OP_STATUS, a, 16'h0);
    chk_sr(8'h80);
    foreach (tbl[i]) begin
      axi_wr(REG_PINS, {29'h0, tbl[i][10:8]}, AXI_OKAY);
      supply_ok <= tbl[i][13];
      fail_op <= tbl[i][12];
      op(tbl[i][18:16], tbl[i][14] ? 18'h0 : a, 16'h0);
      chk_sr(tbl[i][7:0]);
      op(OP_CLEAR, a, 16'h0);
    end
    op(OP_READ, a, 16'h0);
    chk(REG_RDATA, 32'hffff, 32'hffff, AXI_OKAY);
    supply_ok <= 1'b0;
    op(OP_PROGRAM, a, 16'h0);
    supply_ok <= 1'b1;
    axi_wr(REG_PINS, 32'h0, AXI_OKAY);
    axi_wr(REG_PINS, 32'h3, AXI_OKAY);
    op(OP_STATUS, a, 16'h0);
    chk_sr(8'h80);
    op(OP_SUSPEND, a, 16'h0);
    chk_sr(8'h80);
    axi_wr(REG_CTRL, {28'h0, 1'b1, OP_ERASE}, AXI_OKAY);
    do axi_rd(REG_STAT, '{32'h0, 32'h0, AXI_OKAY}, r);
    while (r[STAT_SR_LSB + SR_READY] !== 1'b0);
    op(OP_SUSPEND, a, 16'h0);
    chk_sr(8'hc0);
    op(OP_RESUME, a, 16'h0);
    chk_sr(8'h80);
    chk(5'h18, 32'h0, 32'hffffffff, AXI_SLVERR);
    axi_wr(5'h18, 32'h0, AXI_SLVERR);
    give_verdict();
  end
endmodule
`default_nettype wire
